// ---- design/pci_sideband_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

module pci_sideband_ctrl (
  input wire logic i_clock,
  input wire logic i_nrst,
  // asynchronous pins
  input wire logic i_bus_rst_n,
  input wire logic i_power_good_in,
  input wire logic i_aux_power_present,
  input wire logic i_m66en,
  // bus inputs synchronous to the bus clock
  input wire logic i_gnt_n,
  input wire logic i_frame_n,
  input wire logic i_req64_n,
  input wire logic i_irdy_n,
  input wire logic i_trdy_n,
  // transfer engine side
  input wire logic i_bus_want,
  input wire pci_sideband_pkg::mst_ctrl_t i_mst,
  input wire pci_sideband_pkg::tgt_ctrl_t i_tgt,
  input wire logic i_addr_par_err,
  input wire logic i_data_par_err,
  input wire logic i_special_cycle,
  input wire logic [pci_sideband_pkg::NUM_PORTS-1:0] i_port_irq,
  // power management side
  input wire logic i_wake_event,
  input wire logic i_pme_enable,
  input wire logic i_adv_power_mgmt_wake_enable,
  input wire logic i_pme_clear,
  // bus pins
  output pci_sideband_pkg::pin_drive_t o_req,
  output pci_sideband_pkg::pin_drive_t o_frame,
  output pci_sideband_pkg::pin_drive_t o_req64,
  output pci_sideband_pkg::pin_drive_t o_devsel,
  output pci_sideband_pkg::pin_drive_t o_ack64,
  output pci_sideband_pkg::pin_drive_t o_inta,
  output pci_sideband_pkg::pin_drive_t o_intb,
  output pci_sideband_pkg::pin_drive_t o_serr,
  output pci_sideband_pkg::pin_drive_t o_perr,
  output pci_sideband_pkg::pin_drive_t o_pme,
  // status toward the engine
  output logic o_granted,
  output logic o_phase_done,
  output logic o_bus_active,
  output logic o_bus_66mhz_capable,
  output logic o_d3cold_supported,
  output logic o_pme_status
);

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [3:0] async_sync;

  stage_pipe #(
    .WIDTH(4),
    .DEPTH(pci_sideband_pkg::SYNC_DEPTH),
    .RESET_VALUE(4'h0)
  ) u_async_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_data({i_bus_rst_n, i_power_good_in, i_aux_power_present, i_m66en}),
    .o_data(async_sync)
  );

  logic bus_rst_n_s;
  logic power_good_s;
  logic aux_s;
  logic m66_s;
  assign {bus_rst_n_s, power_good_s, aux_s, m66_s} = async_sync;

  // power good low holds everything, bus reset holds all but wake state and strap status
  logic power_ok;
  logic active;
  assign power_ok = i_nrst && power_good_s;
  assign active = power_ok && bus_rst_n_s;

  // -------------------------------------------------------------------
  // bus input sampling
  // -------------------------------------------------------------------
  // one rising-edge flop per synchronous pin; lock is left unconnected
  // because sole access across transfers is never honoured
  logic gnt_q;
  logic frame_q;
  logic req64_q;
  logic irdy_q;
  logic trdy_q;
  logic wide_seen;
  logic next_gnt_q;
  logic next_frame_q;
  logic next_req64_q;
  logic next_irdy_q;
  logic next_trdy_q;
  logic next_wide_seen;

  always_comb begin
    // inputs are ignored outside the active state
    next_gnt_q = active && (i_gnt_n == pci_sideband_pkg::PIN_ASSERTED);
    next_frame_q = active && (i_frame_n == pci_sideband_pkg::PIN_ASSERTED);
    next_req64_q = active && (i_req64_n == pci_sideband_pkg::PIN_ASSERTED);
    next_irdy_q = active && (i_irdy_n == pci_sideband_pkg::PIN_ASSERTED);
    next_trdy_q = active && (i_trdy_n == pci_sideband_pkg::PIN_ASSERTED);
    next_wide_seen = wide_seen;
    // wide request is caught in the address phase, frame's first cycle
    if (!active) begin
      next_wide_seen = 1'b0;
    end else if (next_frame_q && !frame_q) begin
      next_wide_seen = next_req64_q;
    end
  end

  always_ff @(posedge i_clock) begin
    gnt_q <= next_gnt_q;
    frame_q <= next_frame_q;
    req64_q <= next_req64_q;
    irdy_q <= next_irdy_q;
    trdy_q <= next_trdy_q;
    wide_seen <= next_wide_seen;
  end

  // -------------------------------------------------------------------
  // data parity error pipeline
  // -------------------------------------------------------------------
  logic phase_done;
  logic data_err_detect;
  logic data_err_late;
  assign phase_done = irdy_q && trdy_q;
  // special cycles never report data parity
  assign data_err_detect = phase_done && i_data_par_err && !i_special_cycle && active;

  stage_pipe #(
    .WIDTH(1),
    .DEPTH(pci_sideband_pkg::PERR_DELAY),
    .RESET_VALUE(1'b0)
  ) u_perr_delay (
    .i_clock(i_clock),
    .i_nrst(active),
    .i_data(data_err_detect),
    .o_data(data_err_late)
  );

  // -------------------------------------------------------------------
  // error, wake and status state
  // -------------------------------------------------------------------
  logic addr_err_q;
  logic perr_low_q;
  logic pme_flag;
  logic next_addr_err_q;
  logic next_perr_low_q;
  logic next_pme_flag;

  always_comb begin
    next_addr_err_q = active && i_addr_par_err;
    next_perr_low_q = active && data_err_late;
    next_pme_flag = pme_flag;
    // wake context survives bus reset, lost only with power or core reset
    if (!power_ok) begin
      next_pme_flag = 1'b0;
    end else if (i_wake_event && (i_pme_enable || i_adv_power_mgmt_wake_enable)) begin
      next_pme_flag = 1'b1; // set wins over clear
    end else if (i_pme_clear) begin
      next_pme_flag = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    addr_err_q <= next_addr_err_q;
    perr_low_q <= next_perr_low_q;
    pme_flag <= next_pme_flag;
  end

  // -------------------------------------------------------------------
  // pin drive registers
  // -------------------------------------------------------------------
  pci_sideband_pkg::pin_drive_t next_req;
  pci_sideband_pkg::pin_drive_t next_frame;
  pci_sideband_pkg::pin_drive_t next_req64;
  pci_sideband_pkg::pin_drive_t next_devsel;
  pci_sideband_pkg::pin_drive_t next_ack64;
  pci_sideband_pkg::pin_drive_t next_inta;
  pci_sideband_pkg::pin_drive_t next_intb;
  pci_sideband_pkg::pin_drive_t next_serr;
  pci_sideband_pkg::pin_drive_t next_perr;
  pci_sideband_pkg::pin_drive_t next_pme;

  always_comb begin
    next_req = pci_sideband_pkg::PIN_FLOAT;
    next_frame = pci_sideband_pkg::PIN_FLOAT;
    next_req64 = pci_sideband_pkg::PIN_FLOAT;
    next_devsel = pci_sideband_pkg::PIN_FLOAT;
    next_ack64 = pci_sideband_pkg::PIN_FLOAT;
    next_inta = pci_sideband_pkg::PIN_FLOAT;
    next_intb = pci_sideband_pkg::PIN_FLOAT;
    next_serr = pci_sideband_pkg::PIN_FLOAT;
    next_perr = pci_sideband_pkg::PIN_FLOAT;
    next_pme = pci_sideband_pkg::PIN_FLOAT;
    if (active) begin
      // private request line, always driven while active
      next_req = '{out: !i_bus_want, oe: 1'b1};
      // frame and wide request share one flop timing
      next_frame = '{out: !i_mst.frame_act, oe: i_mst.frame_oe};
      next_req64 = '{out: !(i_mst.frame_act && i_mst.want64), oe: i_mst.frame_oe};
      next_devsel = '{out: !i_tgt.devsel_act, oe: i_tgt.devsel_oe};
      next_ack64 = '{out: !(i_tgt.devsel_act && wide_seen), oe: i_tgt.devsel_oe};
      // level lines held low for as long as the cause stands
      next_inta = '{out: pci_sideband_pkg::PIN_ASSERTED, oe: i_port_irq[0]};
      next_intb = '{out: pci_sideband_pkg::PIN_ASSERTED, oe: i_port_irq[1]};
      // rising edge only, so a held error still gives one clock
      next_serr = '{out: pci_sideband_pkg::PIN_ASSERTED,
                    oe: i_addr_par_err && !addr_err_q};
      // low per errored phase, then one high clock before release
      if (data_err_late) begin
        next_perr = '{out: pci_sideband_pkg::PIN_ASSERTED, oe: 1'b1};
      end else if (perr_low_q) begin
        next_perr = '{out: pci_sideband_pkg::PIN_DEASSERTED, oe: 1'b1};
      end
    end
    // wake line keeps working through bus reset
    if (power_ok) begin
      next_pme = '{out: pci_sideband_pkg::PIN_ASSERTED, oe: next_pme_flag};
    end
  end

  always_ff @(posedge i_clock) begin
    o_req <= next_req;
    o_frame <= next_frame;
    o_req64 <= next_req64;
    o_devsel <= next_devsel;
    o_ack64 <= next_ack64;
    o_inta <= next_inta;
    o_intb <= next_intb;
    o_serr <= next_serr;
    o_perr <= next_perr;
    o_pme <= next_pme;
  end

  // -------------------------------------------------------------------
  // status outputs
  // -------------------------------------------------------------------
  // speed strap is the system's to drive; it is only reported here
  always_ff @(posedge i_clock) begin
    o_granted <= active && gnt_q;
    o_phase_done <= active && phase_done;
    o_bus_active <= active;
    o_bus_66mhz_capable <= power_ok && m66_s;
    o_d3cold_supported <= power_ok && aux_s;
    o_pme_status <= next_pme_flag;
  end

endmodule // pci_sideband_ctrl

`default_nettype wire

// ---- design/pci_sideband_pkg.sv ----
package pci_sideband_pkg;

  // -------------------------------------------------------------------
  // timing and structure constants
  // -------------------------------------------------------------------
  localparam int SYNC_DEPTH = 2;        // flops on every async pin
  localparam int PERR_DELAY = 2;        // clocks from detect to data_err_late; error pin one clock later
  localparam int NUM_PORTS = 2;         // port A and port B interrupt lines
  localparam int CLOCK_PERIOD_NS = 25;  // core clock period

  localparam logic PIN_ASSERTED = 1'b0;   // bus signals are active low
  localparam logic PIN_DEASSERTED = 1'b1;

  // one bus pin as the pad sees it: level to drive and its enable
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

  localparam pin_drive_t PIN_FLOAT = '{out: 1'b1, oe: 1'b0};

  // initiator side request from the transfer engine
  typedef struct packed {
    logic frame_oe;   // engine owns the frame pin
    logic frame_act;  // frame asserted
    logic want64;     // wide transfer wanted
  } mst_ctrl_t;

  // target side answer from the transfer engine
  typedef struct packed {
    logic devsel_oe;
    logic devsel_act;
  } tgt_ctrl_t;

endpackage

// ---- design/stage_pipe.sv ----
`timescale 1ns/1ps
`default_nettype none

// plain shift pipeline: synchroniser or fixed delay line
module stage_pipe #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_data,
  output logic [WIDTH-1:0] o_data
);

  logic [WIDTH-1:0] stage [DEPTH];
  logic [WIDTH-1:0] next_stage [DEPTH];

  // ---------------------------------------------------------------
  // stage chain
  // ---------------------------------------------------------------
  // each stage reads only its predecessor, so stage 0 feeds stage 1 alone
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      always_comb begin
        if (g == 0) begin
          next_stage[g] = i_data;
        end else begin
          next_stage[g] = stage[(g == 0) ? 0 : g - 1];
        end
      end

      always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
          stage[g] <= RESET_VALUE;
        end else begin
          stage[g] <= next_stage[g];
        end
      end
    end
  endgenerate

  assign o_data = stage[DEPTH-1];

endmodule // stage_pipe

`default_nettype wire

// ---- tb/pci_sideband_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module pci_sideband_ctrl_assertions (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_gnt_n,
  input wire logic i_irdy_n,
  input wire logic i_trdy_n,
  input wire pci_sideband_pkg::mst_ctrl_t i_mst,
  input wire logic i_addr_par_err,
  input wire logic i_data_par_err,
  input wire logic i_special_cycle,
  input wire logic [1:0] i_port_irq,
  input wire logic i_wake_event,
  input wire logic i_pme_enable,
  input wire logic i_adv_power_mgmt_wake_enable,
  input wire pci_sideband_pkg::pin_drive_t o_req,
  input wire pci_sideband_pkg::pin_drive_t o_req64,
  input wire pci_sideband_pkg::pin_drive_t o_inta,
  input wire pci_sideband_pkg::pin_drive_t o_serr,
  input wire pci_sideband_pkg::pin_drive_t o_perr,
  input wire pci_sideband_pkg::pin_drive_t o_pme,
  input wire logic o_granted,
  input wire logic o_phase_done,
  input wire logic o_bus_active,
  input wire logic o_pme_status
);
  // one domain; a core reset clears every check
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  wide_req_a: assert property (
    o_bus_active && i_mst.frame_oe && i_mst.frame_act && i_mst.want64 |=>
    !o_bus_active || (o_req64.oe && !o_req64.out)) else $error("wide request missed");
  grant_seen_a: assert property (
    o_bus_active ##1 o_bus_active |-> o_granted == !$past(i_gnt_n, 2))
    else $error("grant status wrong");
  phase_done_a: assert property (
    o_bus_active ##1 o_bus_active |->
    o_phase_done == (!$past(i_irdy_n, 2) && !$past(i_trdy_n, 2))) else $error("phase wrong");
  int_level_a: assert property (
    o_bus_active |-> o_inta.oe == $past(i_port_irq[0]) && !o_inta.out)
    else $error("interrupt a level wrong");
  serr_cause_a: assert property (
    o_bus_active && $rose(i_addr_par_err) |=> !o_bus_active || (o_serr.oe && !o_serr.out))
    else $error("system error missed");
  serr_single_a: assert property (
    o_serr.oe && !o_serr.out |=> !(o_serr.oe && !o_serr.out)) else $error("serr too long");
  perr_delay_a: assert property (
    o_bus_active && !i_irdy_n && !i_trdy_n ##1 o_bus_active && i_data_par_err &&
    !i_special_cycle |-> ##3 (!o_bus_active || (o_perr.oe && !o_perr.out)))
    else $error("parity error pin late");
  float_idle_a: assert property (
    !o_bus_active ##1 !o_bus_active |-> !o_req.oe && !o_inta.oe && !o_serr.oe && !o_perr.oe)
    else $error("pin driven while idle");
  wake_set_a: assert property (
    o_bus_active && i_wake_event && (i_pme_enable || i_adv_power_mgmt_wake_enable) |=>
    o_pme_status && o_pme.oe && !o_pme.out) else $error("wake missed");
  wake_gate_a: assert property (
    !o_pme_status && !i_pme_enable && !i_adv_power_mgmt_wake_enable |=> !o_pme_status)
    else $error("wake without enable");
endmodule // pci_sideband_ctrl_assertions

bind pci_sideband_ctrl pci_sideband_ctrl_assertions pci_sideband_ctrl_assertions_i (
  .i_clock, .i_nrst, .i_gnt_n, .i_irdy_n, .i_trdy_n, .i_mst, .i_addr_par_err,
  .i_data_par_err, .i_special_cycle, .i_port_irq, .i_wake_event, .i_pme_enable,
  .i_adv_power_mgmt_wake_enable, .o_req, .o_req64, .o_inta, .o_serr, .o_perr, .o_pme,
  .o_granted, .o_phase_done, .o_bus_active, .o_pme_status);

`default_nettype wire

// ---- tb/pci_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module pci_host_model (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire pci_sideband_pkg::pin_drive_t i_req,
  input wire logic i_irdy_n,
  input wire logic [1:0] i_wait,
  output logic o_gnt_n,
  output logic o_trdy_n
);
  logic [1:0] gcnt;
  logic [1:0] tcnt;
  // arbiter: grant after the set wait, withdrawn as soon as the request goes
  always_ff @(posedge i_clock) begin
    if (!i_nrst || !(i_req.oe && !i_req.out)) begin
      gcnt <= 2'h0;
      o_gnt_n <= 1'b1;
    end else if (gcnt == i_wait) begin
      o_gnt_n <= 1'b0;
    end else begin
      gcnt <= gcnt + 2'h1;
    end
  end
  // target: ready after the set wait; released pin goes to its pull-up level
  always_ff @(posedge i_clock) begin
    if (!i_nrst || i_irdy_n) begin
      tcnt <= 2'h0;
      o_trdy_n <= 1'b1;
    end else if (tcnt == i_wait) begin
      o_trdy_n <= 1'b0;
    end else begin
      tcnt <= tcnt + 2'h1;
    end
  end
endmodule // pci_host_model

`default_nettype wire

// ---- tb/pci_sideband_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module pci_sideband_ctrl_test;
  logic i_clock, i_nrst, i_bus_rst_n, i_power_good_in, i_aux_power_present, i_m66en;
  logic i_gnt_n, i_frame_n, i_req64_n, i_irdy_n, i_trdy_n, i_bus_want, i_addr_par_err;
  logic i_data_par_err, i_special_cycle, i_wake_event, i_pme_enable, i_pme_clear;
  logic i_adv_power_mgmt_wake_enable, o_granted, o_phase_done, o_bus_active;
  logic o_bus_66mhz_capable, o_d3cold_supported, o_pme_status;
  logic [1:0] i_port_irq, wait_cycles;
  pci_sideband_pkg::mst_ctrl_t i_mst;
  pci_sideband_pkg::tgt_ctrl_t i_tgt;
  pci_sideband_pkg::pin_drive_t o_req, o_frame, o_req64, o_devsel, o_ack64;
  pci_sideband_pkg::pin_drive_t o_inta, o_intb, o_serr, o_perr, o_pme;
  int num_errors, checks;

  pci_sideband_ctrl pci_sideband_ctrl_i (.i_clock, .i_nrst, .i_bus_rst_n, .i_power_good_in,
    .i_aux_power_present, .i_m66en, .i_gnt_n, .i_frame_n, .i_req64_n, .i_irdy_n, .i_trdy_n,
    .i_bus_want, .i_mst, .i_tgt, .i_addr_par_err, .i_data_par_err, .i_special_cycle,
    .i_port_irq, .i_wake_event, .i_pme_enable, .i_adv_power_mgmt_wake_enable, .i_pme_clear,
    .o_req, .o_frame, .o_req64, .o_devsel, .o_ack64, .o_inta, .o_intb, .o_serr, .o_perr,
    .o_pme, .o_granted, .o_phase_done, .o_bus_active, .o_bus_66mhz_capable,
    .o_d3cold_supported, .o_pme_status);
  pci_host_model pci_host_model_i (.i_clock, .i_nrst, .i_req(o_req), .i_irdy_n,
    .i_wait(wait_cycles), .o_gnt_n(i_gnt_n), .o_trdy_n(i_trdy_n));

  // 40 MHz bus clock
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  task tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task done(input string s);
    $display("%s finished, mismatches so far %0d", s, num_errors);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // bounded wait; running out ends the run as a failure
  task automatic wait_on(ref logic s, input logic v);
    for (int k = 0; k < 60 && s !== v; k++) tick(1);
    if (s !== v) begin
      num_errors++;
      final_report;
    end
  endtask

  task t_frame;
    i_mst = '{frame_oe: 1'b1, frame_act: 1'b1, want64: 1'b1};
    tick(1);
    chk({o_frame, o_req64}, 4'h5);
    i_mst.want64 = 1'b0;
    tick(1);
    chk(o_req64, 2'h3);
    i_mst = '0;
    for (int k = 0; k < 2; k++) begin
      {i_frame_n, i_req64_n} = {1'b0, k[0]};
      tick(1);
      i_tgt = '{devsel_oe: 1'b1, devsel_act: 1'b1};
      tick(1);
      chk({o_devsel, o_ack64}, k ? 4'h7 : 4'h5);
      {i_frame_n, i_req64_n} = 2'h3;
      i_tgt = '0;
      tick(2);
    end
    done("frame");
  endtask

  task t_arb;
    wait_cycles = 2'h2;
    i_bus_want = 1'b1;
    tick(1);
    chk(o_req, 2'h1);
    wait_on(o_granted, 1'b1);
    i_bus_want = 1'b0;
    tick(1);
    chk(o_req.out, 1'b1);
    wait_on(o_granted, 1'b0);
    done("arbitration");
  endtask

  // every combination of pending causes, held and then removed
  task t_int;
    for (logic [2:0] v = 3'h1; v < 3'h4; v++) begin
      i_port_irq = v[1:0];
      tick(4);
      chk({o_intb, o_inta}, {1'b0, v[1], 1'b0, v[0]});
      i_port_irq = 2'h0;
      tick(1);
      chk({o_intb, o_inta}, 4'h0);
    end
    done("interrupt");
  endtask

  task t_serr;
    i_addr_par_err = 1'b1;
    tick(1);
    chk(o_serr, 2'h1);
    tick(1);
    chk(o_serr, 2'h0);
    i_addr_par_err = 1'b0;
    done("system error");
  endtask

  // slow target first, then an errored phase, then a special cycle
  task t_parity;
    wait_cycles = 2'h2;
    i_irdy_n = 1'b0;
    wait_on(i_trdy_n, 1'b0);
    tick(1);
    i_irdy_n = 1'b1;
    chk(o_phase_done, 1'b0);
    tick(1);
    chk(o_phase_done, 1'b1);
    wait_cycles = 2'h0;
    for (int k = 0; k < 2; k++) begin
      i_special_cycle = k[0];
      i_irdy_n = 1'b0;
      wait_on(i_trdy_n, 1'b0);
      tick(1);
      i_irdy_n = 1'b1;
      i_data_par_err = 1'b1;
      tick(1);
      i_data_par_err = 1'b0;
      tick(2);
      chk(o_perr.out, k[0]);
      tick(1);
      chk(o_perr, k ? 2'h2 : 2'h3);
    end
    i_special_cycle = 1'b0;
    done("parity");
  endtask

  task t_wake;
    for (int e = 0; e < 4; e++) begin
      {i_pme_enable, i_adv_power_mgmt_wake_enable} = e[1:0];
      i_wake_event = 1'b1;
      tick(1);
      i_wake_event = 1'b0;
      chk({o_pme_status, o_pme}, {e != 0, 1'b0, e != 0});
      i_pme_clear = 1'b1;
      tick(1);
      i_pme_clear = 1'b0;
    end
    done("wake");
  endtask

  // strap pins, then bus reset with wake kept, then power loss
  task t_reset;
    for (int k = 1; k < 3; k++) begin
      {i_m66en, i_aux_power_present} = k[1:0];
      tick(4);
      chk({o_bus_66mhz_capable, o_d3cold_supported}, k[1:0]);
    end
    i_wake_event = 1'b1;
    tick(1);
    {i_wake_event, i_bus_rst_n, i_port_irq} = 4'h3;
    tick(4);
    chk({o_bus_active, o_inta.oe, o_req.oe, o_pme}, 4'h1);
    i_bus_rst_n = 1'b1;
    wait_on(o_bus_active, 1'b1);
    tick(1);
    chk(o_inta, 2'h1);
    {i_port_irq, i_power_good_in} = 3'h0;
    tick(4);
    chk({o_bus_active, o_pme.oe, o_pme_status, o_intb.oe}, 4'h0);
    i_power_good_in = 1'b1;
    wait_on(o_bus_active, 1'b1);
    done("reset");
  endtask

  initial begin
    num_errors = 0;
    checks = 0;
    {i_bus_rst_n, i_power_good_in, i_m66en, i_frame_n, i_req64_n, i_irdy_n} = '1;
    {i_nrst, i_aux_power_present, i_bus_want, i_addr_par_err, i_data_par_err} = '0;
    {i_special_cycle, i_wake_event, i_pme_enable, i_pme_clear, i_port_irq} = '0;
    {i_adv_power_mgmt_wake_enable, wait_cycles, i_mst, i_tgt} = '0;
    tick(12);
    i_nrst = 1'b1;
    wait_on(o_bus_active, 1'b1);
    t_frame;
    t_arb;
    t_int;
    t_serr;
    t_parity;
    t_wake;
    t_reset;
    final_report;
  end
endmodule // pci_sideband_ctrl_test

`default_nettype wire
